// *** hw/cmac_checker.sv ***
// Purpose: grant or deny CPU memory and register accesses by level
// Assumes: region and group decoded outside, rights from segment walk
// Notes: decisions are combinational, ahead of the target strobe
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Operation
// R1: Boot: test ROM, clos EEPROM, clos RAM
// R2: Test: whole ROM, EEPROM, RAM
// R3: Clos level: same memory as boot
// R4: System: application memories, no segment table
// R5: User: segment rights; no RAM exec, ROM write
// R6: Clos reads 64-byte matrix in ROM
// R7: Clos accesses exchange window in RAM
// R8: Boot, clos read security row
// R9: Coprocessor reads EEPROM, owns its RAM
// R10: Boot, test access all register groups; the code denies them the MMU group, per R17
// R11: Clos: firewall read, clos rw, hwc firewall
// R12: System: mmu, sysmgt, firewall, hwc groups
// R13: User hwc rights from current segment
// R14: CPU general registers open to all
// R15: Status high readable in clos, user
// R16: Clock select readable in clos level
// R17: MMU registers only in system level
// R18: Protect registers 0-2 never readable
// R19: Random number register is read-only
// R20: Key registers never readable
// R21: Denied read zero, denied write dropped
// R22: Segment pointers reset to zero
// R23: Five levels from status high, bits
// R24: Segment without rights is disabled
// R25: Decision precedes the target operation
module cmac_checker
  import cmac_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Level sources
  input wire logic [1:0] psw_high_mode_in,
  input wire logic [1:0] internal_mode_in,
  // Memory access
  input wire cmac_mem_req_t mem_req_in,
  input wire cmac_rights_t seg_rights_in,
  output logic mem_grant_out,
  // Register access
  input wire cmac_reg_req_t reg_req_in,
  input wire logic [HWC_BITS-1:0] seg_hwc_rights_in,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_grant_out,
  output logic reg_wr_en_out,
  output logic [7:0] reg_rdata_out,
  // Software side register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Published state
  output logic [2:0] level_out,
  output logic [15:0] seg_ptr_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]  fw_lo;
    logic [7:0]  fw_hi;
    logic [7:0]  xw_base_lo;
    logic [7:0]  xw_base_hi;
    logic [7:0]  xw_size_lo;
    logic [7:0]  xw_size_hi;
    logic [7:0]  seg_ptr_lo;
    logic [7:0]  seg_ptr_hi;
    logic [7:0]  deny_cnt;
    logic [31:0] rdata;
    logic        ack;
  } cmac_state_t;

  cmac_state_t st_q, st_d;
  cmac_level_t lvl;
  logic [15:0] xw_base, xw_size, xw_end;
  logic [16:0] xw_sum;
  logic in_xw, in_acm, mem_ok, reg_ok, hwc_fw, hwc_seg, reg_rd;
  logic [7:0] hwc_idx;
  logic bus_wr, sys_ok, fw_wr_ok;
  logic [15:0] fw_bits;

  // ==========================================================
  // Level decode
  // R23: level from status bits
  always_comb begin
    unique case (internal_mode_in)
      2'b00: lvl = LVL_BOOT;
      2'b01: lvl = LVL_TEST;
      2'b10: lvl = LVL_CLOS;
      default: lvl = psw_high_mode_in[0] ? LVL_SYS : LVL_USER;
    endcase
  end

  // ==========================================================
  // Exchange window and matrix
  assign xw_base = {st_q.xw_base_hi, st_q.xw_base_lo};
  assign xw_size = {st_q.xw_size_hi, st_q.xw_size_lo};
  assign xw_sum = {1'b0, xw_base} + {1'b0, xw_size};
  assign xw_end = xw_sum[15:0];
  // A window that wraps past the top reaches the end of RAM
  // R7: window range check
  assign in_xw = (mem_req_in.region == RG_APP_RAM) &&
    (mem_req_in.addr >= xw_base) &&
    (xw_sum[16] || mem_req_in.addr < xw_end);
  // R6: matrix range
  assign in_acm = (mem_req_in.region == RG_ACM_ROM) ||
    ((mem_req_in.region == RG_APP_ROM) &&
    (mem_req_in.addr >= ACM_BASE) &&
    (mem_req_in.addr < ACM_BASE + ACM_BYTES));

  // ==========================================================
  // Memory decision
  always_comb begin
    mem_ok = 1'b0;
    if (mem_req_in.pkc) begin
      // R9: coprocessor rights
      mem_ok = ((mem_req_in.op == OP_READ) &&
        (mem_req_in.region inside {RG_CLOS_EE, RG_APP_EE, RG_SEC_ROW})) ||
        ((mem_req_in.op != OP_EXEC) && (mem_req_in.region == RG_PKC_RAM));
    end else begin
      unique case (lvl)
        LVL_BOOT, LVL_CLOS: begin
          // R1: boot memory rights
          // R3: clos memory rights
          unique case (mem_req_in.region)
            RG_TEST_ROM: mem_ok = (mem_req_in.op != OP_WRITE);
            RG_CLOS_EE: mem_ok = 1'b1;
            RG_CLOS_RAM: mem_ok = (mem_req_in.op != OP_EXEC);
            // R8: security row read
            RG_SEC_ROW: mem_ok = (mem_req_in.op == OP_READ);
            default: mem_ok = 1'b0;
          endcase
          if (lvl == LVL_CLOS) begin
            // R6: matrix read
            if (in_acm && mem_req_in.op == OP_READ)
              mem_ok = 1'b1;
            // R7: window data access
            if (in_xw && mem_req_in.op != OP_EXEC)
              mem_ok = 1'b1;
          end
        end
        LVL_TEST: begin
          // R2: whole memories
          unique case (mem_req_in.region)
            RG_TEST_ROM, RG_APP_ROM, RG_ACM_ROM:
              mem_ok = (mem_req_in.op != OP_WRITE);
            RG_CLOS_EE, RG_APP_EE, RG_SEC_ROW: mem_ok = 1'b1;
            RG_CLOS_RAM, RG_APP_RAM, RG_PKC_RAM:
              mem_ok = (mem_req_in.op != OP_EXEC);
            default: mem_ok = 1'b0;
          endcase
        end
        LVL_SYS: begin
          // R4: application memories
          unique case (mem_req_in.region)
            RG_APP_ROM, RG_ACM_ROM: mem_ok = (mem_req_in.op != OP_WRITE);
            RG_APP_EE, RG_SEC_ROW: mem_ok = 1'b1;
            RG_APP_RAM: mem_ok = (mem_req_in.op != OP_EXEC);
            default: mem_ok = 1'b0;
          endcase
        end
        default: begin
          // R5: segment rights, fixed limits
          // R24: no rights means disabled
          unique case (mem_req_in.region)
            RG_APP_ROM, RG_ACM_ROM: mem_ok =
              (mem_req_in.op == OP_READ && seg_rights_in.rd) ||
              (mem_req_in.op == OP_EXEC && seg_rights_in.ex);
            RG_APP_EE: mem_ok =
              (mem_req_in.op == OP_READ && seg_rights_in.rd) ||
              (mem_req_in.op == OP_WRITE && seg_rights_in.wr) ||
              (mem_req_in.op == OP_EXEC && seg_rights_in.ex);
            RG_APP_RAM: mem_ok =
              (mem_req_in.op == OP_READ && seg_rights_in.rd) ||
              (mem_req_in.op == OP_WRITE && seg_rights_in.wr);
            default: mem_ok = 1'b0;
          endcase
        end
      endcase
    end
  end

  // R25: grant gates the strobe
  assign mem_grant_out = mem_req_in.valid && mem_ok;

  // ==========================================================
  // Register decision
  // Addresses below the range wrap high and fall outside it
  assign hwc_idx = reg_req_in.addr - HWC_BASE;
  assign fw_bits = {st_q.fw_hi, st_q.fw_lo};
  assign hwc_fw = (hwc_idx < 8'(HWC_BITS)) &&
    fw_bits[hwc_idx[3:0]];
  assign hwc_seg = (hwc_idx < 8'(HWC_BITS)) &&
    seg_hwc_rights_in[hwc_idx[3:0]];
  assign reg_rd = !reg_req_in.wr;

  // ==========================================================
  // Register group rights
  always_comb begin
    reg_ok = 1'b0;
    unique case (lvl)
      LVL_BOOT, LVL_TEST: begin
        // R10: full group access
        reg_ok = 1'b1;
      end
      LVL_CLOS: begin
        // R11: clos group rights
        unique case (reg_req_in.group)
          GR_FWCFG: reg_ok = reg_rd;
          GR_CLOS: reg_ok = 1'b1;
          GR_HWC: reg_ok = hwc_fw ||
            // R16: clock select read
            (reg_rd && reg_req_in.addr == SFR_CLOCK_SEL);
          default: reg_ok = 1'b0;
        endcase
      end
      LVL_SYS: begin
        // R12: system group rights
        reg_ok = reg_req_in.group inside
          {GR_MMU, GR_SYSMGT, GR_FWCFG, GR_HWC};
      end
      default: begin
        // R13: current segment rights
        reg_ok = (reg_req_in.group == GR_HWC) && hwc_seg;
      end
    endcase
    // R15: status high readable
    if ((lvl == LVL_CLOS || lvl == LVL_USER) && reg_rd &&
        reg_req_in.group == GR_SYSMGT && reg_req_in.addr == SFR_PSW_HIGH)
      reg_ok = 1'b1;
    // R14: cpu registers open
    if (reg_req_in.group == GR_CPU)
      reg_ok = 1'b1;
    // R17: mmu only in system
    if (reg_req_in.group == GR_MMU && lvl != LVL_SYS)
      reg_ok = 1'b0;
    // R18: protect registers unreadable
    if (reg_rd && reg_req_in.addr inside
        {SFR_PROT_0, SFR_PROT_1, SFR_PROT_2})
      reg_ok = 1'b0;
    // R19: random number read-only
    if (!reg_rd && reg_req_in.addr == SFR_RAND_NUM)
      reg_ok = 1'b0;
    // R20: keys unreadable
    if (reg_rd && reg_req_in.addr inside {SFR_SYM_KEY, SFR_DES_KEY})
      reg_ok = 1'b0;
  end

  assign reg_grant_out = reg_req_in.valid && reg_ok;
  // R21: denied write dropped
  assign reg_wr_en_out = reg_grant_out && reg_req_in.wr;
  // Zero rather than stale data, so a denial leaks nothing
  // R21: denied read zero
  assign reg_rdata_out = (reg_grant_out && reg_rd) ? reg_rdata_in : RST_ZERO;

  // ==========================================================
  // Configuration registers over the bus
  // Writes to the firewall and pointer copies need system level;
  // boot and test may also set up the firewall before handover.
  assign sys_ok = (lvl == LVL_SYS);
  assign fw_wr_ok = sys_ok || (lvl inside {LVL_BOOT, LVL_TEST});
  // Writes land at the edge where waitrequest is low
  assign bus_wr = avs_write && st_q.ack;

  always_comb begin
    st_d = st_q;
    st_d.ack = (avs_read || avs_write) && !st_q.ack;
    if (bus_wr) begin
      unique case (avs_address)
        OFS_FW_CTRL_LOW: if (fw_wr_ok)
          st_d.fw_lo = avs_writedata[7:0];
        OFS_FW_CTRL_HIGH: if (fw_wr_ok)
          st_d.fw_hi = avs_writedata[7:0];
        OFS_XW_BASE_LOW: if (sys_ok) st_d.xw_base_lo = avs_writedata[7:0];
        OFS_XW_BASE_HIGH: if (sys_ok) st_d.xw_base_hi = avs_writedata[7:0];
        OFS_XW_SIZE_LOW: if (sys_ok) st_d.xw_size_lo = avs_writedata[7:0];
        OFS_XW_SIZE_HIGH: if (sys_ok) st_d.xw_size_hi = avs_writedata[7:0];
        // R17: pointer writes system only
        OFS_SEG_PTR_LOW: if (sys_ok) st_d.seg_ptr_lo = avs_writedata[7:0];
        OFS_SEG_PTR_HIGH: if (sys_ok) st_d.seg_ptr_hi = avs_writedata[7:0];
        default: ;
      endcase
    end
    // Saturating count of cycles with a denied access, for software visibility
    if (((mem_req_in.valid && !mem_ok) || (reg_req_in.valid && !reg_ok))
        && st_q.deny_cnt != 8'hFF)
      st_d.deny_cnt = st_q.deny_cnt + 8'h01;
    st_d.rdata = 32'h00000000;
    if (avs_read && !st_q.ack) begin
      unique case (avs_address)
        OFS_FW_CTRL_LOW: st_d.rdata[7:0] = st_q.fw_lo;
        OFS_FW_CTRL_HIGH: st_d.rdata[7:0] = st_q.fw_hi;
        OFS_XW_BASE_LOW: st_d.rdata[7:0] = st_q.xw_base_lo;
        OFS_XW_BASE_HIGH: st_d.rdata[7:0] = st_q.xw_base_hi;
        OFS_XW_SIZE_LOW: st_d.rdata[7:0] = st_q.xw_size_lo;
        OFS_XW_SIZE_HIGH: st_d.rdata[7:0] = st_q.xw_size_hi;
        OFS_SEG_PTR_LOW: st_d.rdata[7:0] = st_q.seg_ptr_lo;
        OFS_SEG_PTR_HIGH: st_d.rdata[7:0] = st_q.seg_ptr_hi;
        OFS_LEVEL: st_d.rdata[2:0] = lvl;
        OFS_DENY_CNT: st_d.rdata[7:0] = st_q.deny_cnt;
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      // R22: pointers reset zero
      // Zero pointers keep every segment disabled until set up
      st_q.fw_lo <= RST_ZERO;
      st_q.fw_hi <= RST_ZERO;
      st_q.xw_base_lo <= RST_ZERO;
      st_q.xw_base_hi <= RST_ZERO;
      st_q.xw_size_lo <= RST_ZERO;
      st_q.xw_size_hi <= RST_ZERO;
      st_q.seg_ptr_lo <= RST_ZERO;
      st_q.seg_ptr_hi <= RST_ZERO;
      st_q.deny_cnt <= RST_ZERO;
      st_q.rdata <= 32'h00000000;
      st_q.ack <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign level_out = lvl;
  assign seg_ptr_out = {st_q.seg_ptr_hi, st_q.seg_ptr_lo};

endmodule // cmac_checker

// *** hw/cmac_pkg.sv ***
// Purpose: shared types and constants for the mode access checker
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register offsets and field positions are fixed here
package cmac_pkg;

  // ==========================================================
  // Privilege levels and operations
  typedef enum logic [2:0] {
    LVL_BOOT, LVL_TEST, LVL_CLOS, LVL_SYS, LVL_USER
  } cmac_level_t;

  typedef enum logic [1:0] {
    OP_READ, OP_WRITE, OP_EXEC
  } cmac_op_t;

  // Memory regions as decoded by the address map outside
  typedef enum logic [3:0] {
    RG_TEST_ROM, RG_APP_ROM, RG_ACM_ROM,
    RG_CLOS_EE, RG_APP_EE, RG_SEC_ROW,
    RG_CLOS_RAM, RG_APP_RAM, RG_PKC_RAM, RG_NONE
  } cmac_region_t;

  // Register groups
  typedef enum logic [2:0] {
    GR_MMU, GR_SYSMGT, GR_FWCFG, GR_CLOS, GR_TEST, GR_HWC, GR_CPU
  } cmac_group_t;

  // ==========================================================
  // Memory request and segment rights
  typedef struct packed {
    logic         valid;
    logic         pkc;
    cmac_op_t     op;
    cmac_region_t region;
    logic [15:0]  addr;
  } cmac_mem_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
  } cmac_rights_t;

  // Register request
  typedef struct packed {
    logic        valid;
    logic        wr;
    cmac_group_t group;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } cmac_reg_req_t;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_FW_CTRL_LOW = 8'h00;
  localparam logic [7:0] OFS_FW_CTRL_HIGH = 8'h04;
  localparam logic [7:0] OFS_XW_BASE_LOW = 8'h08;
  localparam logic [7:0] OFS_XW_BASE_HIGH = 8'h0C;
  localparam logic [7:0] OFS_XW_SIZE_LOW = 8'h10;
  localparam logic [7:0] OFS_XW_SIZE_HIGH = 8'h14;
  localparam logic [7:0] OFS_SEG_PTR_LOW = 8'h18;
  localparam logic [7:0] OFS_SEG_PTR_HIGH = 8'h1C;
  localparam logic [7:0] OFS_LEVEL = 8'h20;
  localparam logic [7:0] OFS_DENY_CNT = 8'h24;

  // Register indices used by the locks (CPU register address)
  localparam logic [7:0] SFR_PSW_HIGH = 8'hD1;
  localparam logic [7:0] SFR_CLOCK_SEL = 8'hA1;
  localparam logic [7:0] SFR_PROT_0 = 8'hB0;
  localparam logic [7:0] SFR_PROT_1 = 8'hB1;
  localparam logic [7:0] SFR_PROT_2 = 8'hB2;
  localparam logic [7:0] SFR_RAND_NUM = 8'hC0;
  localparam logic [7:0] SFR_SYM_KEY = 8'hC1;
  localparam logic [7:0] SFR_DES_KEY = 8'hC2;

  // Hardware register index range mapped to firewall bits
  localparam logic [7:0] HWC_BASE = 8'hC0;
  localparam int HWC_BITS = 16;

  // Access condition matrix size
  localparam logic [15:0] ACM_BYTES = 16'h0040;
  localparam logic [15:0] ACM_BASE = 16'h0000;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [2:0] RST_LEVEL = 3'h0;
  localparam int MAX_SEGMENTS = 64;

endpackage

// *** verification/cmac_checker_asserts.sv ***
// Purpose: concurrent checks on the mode access checker ports
// Assumes: one clock, synchronous active-high reset
// Notes: grants are combinational, so each is judged at the edge
`timescale 1ns/1ps
module cmac_asserts
  import cmac_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Level and requests
  input wire logic [1:0] psw_high_mode_in,
  input wire logic [1:0] internal_mode_in,
  input wire cmac_mem_req_t mem_req_in,
  input wire cmac_reg_req_t reg_req_in,
  // Decisions
  input wire logic mem_grant_out,
  input wire logic reg_grant_out,
  input wire logic reg_wr_en_out,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [2:0] level_out,
  input wire logic [15:0] seg_ptr_out
);
  // ==========================================================
  // Request sequences
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence rd_at_s(logic [7:0] a);
    reg_req_in.valid && !reg_req_in.wr && reg_req_in.addr == a;
  endsequence
  sequence wr_at_s(logic [7:0] a);
    reg_req_in.valid && reg_req_in.wr && reg_req_in.addr == a;
  endsequence
  // ==========================================================
  // Checks
  // level decode
  level_map_a: assert property (level_out ==
    (internal_mode_in != 2'h3 ? {1'b0, internal_mode_in} :
    psw_high_mode_in[0] ? 3'h3 : 3'h4)) else $error("level decode");
  wr_strobe_a: assert property (reg_wr_en_out ==
    (reg_grant_out && reg_req_in.wr)) else $error("write strobe");
  deny_zero_a: assert property (!reg_grant_out |->
    reg_rdata_out == 8'h00) else $error("denied read leaks");
  prot_lock_a: assert property (rd_at_s(SFR_PROT_0) or
    rd_at_s(SFR_PROT_1) or rd_at_s(SFR_PROT_2) |-> !reg_grant_out)
    else $error("protect register read");
  key_lock_a: assert property (rd_at_s(SFR_SYM_KEY) or
    rd_at_s(SFR_DES_KEY) |-> !reg_grant_out) else $error("key read");
  rand_ro_a: assert property (wr_at_s(SFR_RAND_NUM) |->
    !reg_wr_en_out) else $error("random register written");
  mmu_sys_a: assert property (reg_req_in.valid &&
    reg_req_in.group == GR_MMU && level_out != LVL_SYS |->
    !reg_grant_out) else $error("mmu group open");
  cpu_open_a: assert property (reg_req_in.valid && reg_req_in.wr &&
    reg_req_in.group == GR_CPU && reg_req_in.addr != SFR_RAND_NUM
    |-> reg_grant_out) else $error("cpu group closed");
  user_bar_a: assert property (mem_req_in.valid &&
    !mem_req_in.pkc && level_out == LVL_USER &&
    (mem_req_in.op == OP_EXEC && mem_req_in.region == RG_APP_RAM ||
    mem_req_in.op == OP_WRITE &&
    mem_req_in.region inside {RG_APP_ROM, RG_ACM_ROM})
    |-> !mem_grant_out) else $error("user memory bar");
  ptr_reset_a: assert property ($fell(sys_rst_in) |->
    seg_ptr_out == 16'h0000) else $error("pointer not zero");
endmodule // cmac_asserts

bind cmac_checker cmac_asserts chk_u (.clock_in, .sys_rst_in,
  .psw_high_mode_in, .internal_mode_in, .mem_req_in, .reg_req_in,
  .mem_grant_out, .reg_grant_out, .reg_wr_en_out, .reg_rdata_out,
  .level_out, .seg_ptr_out);

// *** verification/cmac_sfr_model.sv ***
// Purpose: register targets behind the checker
// Assumes: writes land only on the checker's write strobe
// Notes: contents never start at zero, so a leak is not a denial
`timescale 1ns/1ps
module cmac_sfr_model
  import cmac_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Target side
  input wire cmac_reg_req_t reg_req_in,
  input wire logic reg_wr_en_in,
  output logic [7:0] reg_rdata_out
);
  logic [7:0] regs_q [256];
  initial foreach (regs_q[i]) regs_q[i] = 8'h80 | i[7:0];
  always @(posedge clock_in) begin
    if (reg_wr_en_in) regs_q[reg_req_in.addr] <= reg_req_in.wdata;
  end
  assign reg_rdata_out = regs_q[reg_req_in.addr];
endmodule // cmac_sfr_model

// *** verification/test_cpu_mode_access_control.sv ***
// Purpose: self-checking bench for the mode access checker
// Assumes: bus answers one cycle after it takes a request
// Notes: random requests per level compared with a rule model
`timescale 1ns/1ps
module test_cpu_mode_access_control
  import cmac_pkg::*;
;
  logic clock_in = 0, sys_rst_in = 1, ar = 0, aw = 0;
  logic [1:0] psw_q = 0, int_q = 0;
  cmac_mem_req_t mreq = '0;
  cmac_rights_t segr = '0;
  cmac_reg_req_t rreq = '0;
  logic [15:0] hwcr = 0, fw = 0, seed = 16'h001B, sptr;
  logic [7:0] aa = 0, rdi, rdo;
  logic [31:0] awd = 0, ard;
  logic mg, rg, wen, awt;
  logic [2:0] lvo;
  int fails = 0, n_checks = 0, xb = 0, xs = 0;
  always #5 clock_in = ~clock_in;
  cmac_checker dut_u (.clock_in, .sys_rst_in, .psw_high_mode_in(psw_q),
    .internal_mode_in(int_q), .mem_req_in(mreq), .seg_rights_in(segr),
    .mem_grant_out(mg), .reg_req_in(rreq), .seg_hwc_rights_in(hwcr),
    .reg_rdata_in(rdi), .reg_grant_out(rg), .reg_wr_en_out(wen),
    .reg_rdata_out(rdo), .avs_address(aa), .avs_read(ar),
    .avs_write(aw), .avs_writedata(awd), .avs_readdata(ard),
    .avs_waitrequest(awt), .level_out(lvo), .seg_ptr_out(sptr));
  cmac_sfr_model far_u (.clock_in, .reg_req_in(rreq),
    .reg_wr_en_in(wen), .reg_rdata_out(rdi));
  // ==========================================================
  // Helpers
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic bus(input bit w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    ar <= !w;
    aw <= w;
    aa <= a;
    awd <= d;
    do begin
      @(posedge clock_in);
      n++;
    end while (awt !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    q = ard;
    ar <= 0;
    aw <= 0;
    @(posedge clock_in);
  endtask
  task automatic set_lv(input int lv);
    logic [15:0] r;
    r = rnd();
    int_q <= lv > 2 ? 2'h3 : lv[1:0];
    psw_q <= {r[0], lv == 3};
    @(posedge clock_in);
  endtask
  // ==========================================================
  // Rule model
  function automatic bit exp_mem(int lv, cmac_mem_req_t m, cmac_rights_t s);
    bit r, w, x;
    int g;
    r = m.op == OP_READ;
    w = m.op == OP_WRITE;
    x = m.op == OP_EXEC;
    g = m.region;
    if (!m.valid) return 0;
    if (m.pkc) return r && g inside {3, 4, 5} || !x && g == 8;
    if (lv == 1) return g < 3 && !w || g inside {3, 4, 5} || g > 5 && !x;
    if (lv == 3) return g inside {1, 2} && !w || g inside {4, 5} ||
      g == 7 && !x;
    if (lv == 4) return g inside {1, 2} && (r && s.rd || x && s.ex) ||
      g == 4 && (r && s.rd || w && s.wr || x && s.ex) ||
      g == 7 && (r && s.rd || w && s.wr);
    return g == 0 && !w || g == 3 || g == 6 && !x || g == 5 && r ||
      lv == 2 && (r && (g == 2 || g == 1 && m.addr < 64) ||
      g == 7 && !x && m.addr >= xb && m.addr < xb + xs);
  endfunction
  function automatic bit exp_reg(int lv, cmac_reg_req_t q, logic [15:0] h);
    if (!q.valid) return 0;
    if (!q.wr && q.addr inside {8'hB0, 8'hB1, 8'hB2, 8'hC1, 8'hC2}) return 0;
    if (q.wr && q.addr == SFR_RAND_NUM) return 0;
    if (q.group == GR_CPU) return 1;
    if (q.group == GR_MMU) return lv == 3;
    if (lv < 2) return 1;
    if (lv == 3) return q.group inside {GR_SYSMGT, GR_FWCFG, GR_HWC};
    if (!q.wr && q.group == GR_SYSMGT && q.addr == SFR_PSW_HIGH) return 1;
    if (q.group == GR_HWC && q.addr[7:4] == 4'hC)
      return lv == 2 ? fw[q.addr[3:0]] : h[q.addr[3:0]];
    if (lv == 4) return 0;
    return q.group == GR_CLOS || !q.wr && (q.group == GR_FWCFG ||
      q.group == GR_HWC && q.addr == SFR_CLOCK_SEL);
  endfunction
  // ==========================================================
  // Tests
  localparam logic [15:0] CFG [6] = '{16'h0800, 16'h0C01, 16'h1080,
    16'h1400, 16'h1834, 16'h1C12};
  localparam logic [7:0] ADR [10] = '{8'hA1, 8'hB0, 8'hB2, 8'hC0, 8'hC1,
    8'hC3, 8'hC8, 8'hCF, 8'hD1, 8'h10};
  initial begin
    #500000;
    fails++;
    wrap_up();
  end
  initial begin
    logic [31:0] q;
    logic [15:0] r;
    cmac_mem_req_t m;
    cmac_reg_req_t rq;
    bit eg;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 0;
    @(posedge clock_in);
    chk(sptr, 0);
    for (int a = 0; a <= 8'h40; a += 4) begin
      bus(0, a[7:0], 0, q);
      chk(q, 0);
    end
    $display("test reset values done");
    bus(1, OFS_FW_CTRL_LOW, 32'h05, q);
    bus(1, OFS_FW_CTRL_HIGH, 32'h80, q);
    fw = 16'h8005;
    set_lv(4);
    bus(1, OFS_FW_CTRL_LOW, 32'hFF, q);
    bus(0, OFS_FW_CTRL_LOW, 0, q);
    chk(q, 32'h05);
    set_lv(3);
    foreach (CFG[i]) bus(1, CFG[i][15:8], {24'h0, CFG[i][7:0]}, q);
    xb = 16'h0100;
    xs = 16'h0080;
    chk(sptr, 16'h1234);
    bus(0, OFS_LEVEL, 0, q);
    chk(q, 3);
    $display("test configuration done");
    for (int lv = 0; lv < 5; lv++) begin
      set_lv(lv);
      repeat (150) begin
        r = rnd();
        m.valid = r[4] | r[5];
        m.pkc = r[6] & r[7] & r[8];
        m.op = cmac_op_t'(r[10:9] % 3);
        m.region = cmac_region_t'(r[3:0] % 9);
        m.addr = rnd() & 16'h01FF;
        mreq <= m;
        segr <= cmac_rights_t'(r[13:11]);
        r = rnd();
        rq.valid = r[0] | r[1];
        rq.wr = r[2];
        rq.group = cmac_group_t'(r[5:3] % 7);
        rq.addr = ADR[r[9:6] % 10];
        rq.wdata = r[15:8];
        rreq <= rq;
        hwcr <= rnd();
        @(negedge clock_in);
        chk(mg, exp_mem(lv, m, segr));
        eg = exp_reg(lv, rq, hwcr);
        chk(rg, eg);
        chk(wen, eg && rq.wr);
        chk(rdo, eg && !rq.wr ? rdi : 8'h00);
        chk(lvo, lv);
        @(posedge clock_in);
      end
      $display("test level %0d done", lv);
    end
    wrap_up();
  end
endmodule // test_cpu_mode_access_control
